// file: core/pfpg_top.sv
`timescale 1ns/10ps
module pfpg_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protection byte fetch from the flash array during the reset sequence.
  output logic load_req,
  output logic [22:0] load_addr,
  input wire logic load_valid,
  input wire logic [7:0] load_byte,
  input wire logic load_dbfault,
  // Command launch toward the flash controller.
  output logic cmd_go,
  output pfpg_pkg::pfpg_cmd_s cmd,
  // Protection state for the rest of the module.
  output pfpg_pkg::pfpg_prot_s prot_state,
  output logic violation
);

  pfpg_pkg::pfpg_state_e state_r;
  pfpg_pkg::pfpg_prot_s prot_r;
  logic violation_r;
  logic load_fault_r;
  pfpg_pkg::pfpg_result_e result_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic cmd_go_r;
  pfpg_pkg::pfpg_cmd_s cmd_r;
  logic load_req_r;

  logic access;
  logic commit;
  logic mapped;
  logic wr_prot;
  logic wr_status;
  logic wr_cmd;
  pfpg_pkg::pfpg_prot_s prot_nxt;
  pfpg_pkg::pfpg_cmd_s cmd_nxt;
  logic [2:0] scen_cur;
  logic [2:0] scen_new;
  logic [7:0] allowed_row;
  logic move_ok;
  logic addr_protected;
  logic block_protected;
  logic cmd_refused_prot;
  logic [31:0] read_word;

  // APB decode. The access phase takes one wait state so that read data comes from a flop.
  assign access = psel && penable;
  assign commit = access && pready_r;
  assign mapped = (paddr == pfpg_pkg::PROT_OFFSET) ||
                  (paddr == pfpg_pkg::STATUS_OFFSET) ||
                  (paddr == pfpg_pkg::COMMAND_OFFSET) ||
                  (paddr == pfpg_pkg::RESULT_OFFSET);
  assign wr_prot = commit && pwrite && (paddr == pfpg_pkg::PROT_OFFSET);
  assign wr_status = commit && pwrite && (paddr == pfpg_pkg::STATUS_OFFSET);
  assign wr_cmd = commit && pwrite && (paddr == pfpg_pkg::COMMAND_OFFSET);

  // Candidate register value built from the write data in the write cycle.
  always_comb begin
    prot_nxt.polarity = pwdata[pfpg_pkg::POLARITY_BIT];
    // The reserved bit holds what was loaded; software cannot change it.
    prot_nxt.reserved_nv = prot_r.reserved_nv;
    prot_nxt.high_range_disable = pwdata[pfpg_pkg::HIGH_DISABLE_BIT];
    prot_nxt.low_range_disable = pwdata[pfpg_pkg::LOW_DISABLE_BIT];
    if (prot_r.high_range_disable) begin
      prot_nxt.high_range_size = pwdata[4:3];
    end else begin
      prot_nxt.high_range_size = prot_r.high_range_size;
    end
    if (prot_r.low_range_disable) begin
      prot_nxt.low_range_size = pwdata[1:0];
    end else begin
      prot_nxt.low_range_size = prot_r.low_range_size;
    end
  end

  // Scenario numbers come from a table, so the mapping can be changed without touching logic.
  assign scen_cur = pfpg_pkg::SCENARIO_OF_CODE[{prot_r.polarity,
                                                 prot_r.high_range_disable,
                                                 prot_r.low_range_disable}];
  assign scen_new = pfpg_pkg::SCENARIO_OF_CODE[{prot_nxt.polarity,
                                                 prot_nxt.high_range_disable,
                                                 prot_nxt.low_range_disable}];
  assign allowed_row = pfpg_pkg::TRANSITION_ROW[scen_cur];
  assign move_ok = allowed_row[scen_new];

  // Command word fields.
  assign cmd_nxt.addr = pwdata[22:0];
  assign cmd_nxt.op = pfpg_pkg::pfpg_op_e'(pwdata[pfpg_pkg::CMD_OP_LSB +: 2]);

  pfpg_range_check u_range_check (
    .prot(prot_r),
    .addr(cmd_nxt.addr),
    .addr_protected(addr_protected),
    .block_protected(block_protected)
  );

  // A block erase looks at the whole block; program and sector erase at the target address.
  always_comb begin
    case (cmd_nxt.op)
      pfpg_pkg::OP_PROGRAM: cmd_refused_prot = addr_protected;
      pfpg_pkg::OP_SECTOR_ERASE: cmd_refused_prot = addr_protected;
      pfpg_pkg::OP_BLOCK_ERASE: cmd_refused_prot = block_protected;
      default: cmd_refused_prot = 1'b0;
    endcase
  end

  // Reset-sequence fetch of the protection byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pfpg_pkg::ST_LOAD;
      load_req_r <= 1'b0;
      load_fault_r <= 1'b0;
    end else begin
      case (state_r)
        pfpg_pkg::ST_LOAD: begin
          load_req_r <= !load_valid;
          if (load_valid) begin
            state_r <= pfpg_pkg::ST_RUN;
            load_fault_r <= load_dbfault;
          end
        end
        pfpg_pkg::ST_RUN: begin
          load_req_r <= 1'b0;
        end
        default: begin
          state_r <= pfpg_pkg::ST_LOAD;
          load_req_r <= 1'b0;
        end
      endcase
    end
  end

  // Protection register. Until the byte arrives it holds the fully protected value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_r <= pfpg_pkg::PROT_FULL_VALUE;
    end else if (state_r == pfpg_pkg::ST_LOAD) begin
      if (load_valid && load_dbfault) begin
        prot_r <= ~pfpg_pkg::PROT_FAULT_MASK;
      end else if (load_valid) begin
        prot_r <= load_byte;
      end
    end else if (wr_prot && move_ok) begin
      // A disallowed move leaves every bit untouched, size fields included.
      prot_r <= prot_nxt;
    end
  end

  // Violation flag. A new violation beats a clear written in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      violation_r <= 1'b0;
    end else if (wr_cmd && !violation_r && (state_r == pfpg_pkg::ST_RUN)
                 && cmd_refused_prot) begin
      violation_r <= 1'b1;
    end else if (wr_status && pwdata[pfpg_pkg::VIOLATION_BIT]) begin
      violation_r <= 1'b0;
    end
  end

  // Command launch. Commands are refused while the fetch is pending or the flag is up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_go_r <= 1'b0;
      cmd_r <= '0;
      result_r <= pfpg_pkg::RES_NONE;
    end else begin
      cmd_go_r <= 1'b0;
      if (wr_cmd) begin
        if (violation_r || (state_r != pfpg_pkg::ST_RUN)) begin
          result_r <= pfpg_pkg::RES_BLOCKED;
        end else if (cmd_refused_prot) begin
          result_r <= pfpg_pkg::RES_PROTECTED;
        end else if (cmd_nxt.op == pfpg_pkg::OP_ILLEGAL) begin
          result_r <= pfpg_pkg::RES_BLOCKED;
        end else begin
          cmd_go_r <= 1'b1;
          cmd_r <= cmd_nxt;
          result_r <= pfpg_pkg::RES_LAUNCHED;
        end
      end
    end
  end

  // Read mux.
  always_comb begin
    read_word = 32'h0000_0000;
    case (paddr)
      pfpg_pkg::PROT_OFFSET: read_word[7:0] = prot_r;
      pfpg_pkg::STATUS_OFFSET: read_word[pfpg_pkg::VIOLATION_BIT] = violation_r;
      pfpg_pkg::COMMAND_OFFSET: read_word = {6'h00, cmd_r.op, 1'b0, cmd_r.addr};
      pfpg_pkg::RESULT_OFFSET: begin
        read_word[1:0] = result_r;
        read_word[pfpg_pkg::RESULT_LOADED_BIT] = (state_r == pfpg_pkg::ST_RUN);
        read_word[pfpg_pkg::RESULT_LOAD_FAULT_BIT] = load_fault_r;
      end
      default: read_word = 32'h0000_0000;
    endcase
  end

  // APB answer: pready for one cycle after one wait state, error on unmapped address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (access && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r <= pwrite ? 32'h0000_0000 : read_word;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign load_req = load_req_r;
  assign load_addr = pfpg_pkg::PROT_BYTE_ADDR;
  assign cmd_go = cmd_go_r;
  assign cmd = cmd_r;
  assign prot_state = prot_r;
  assign violation = violation_r;

endmodule // pfpg_top

// file: core/pfpg_pkg.sv
package pfpg_pkg;

  // APB register byte offsets.
  localparam logic [7:0] PROT_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COMMAND_OFFSET = 8'h08;
  localparam logic [7:0] RESULT_OFFSET = 8'h0c;

  // Field positions.
  localparam int POLARITY_BIT = 7;
  localparam int RESERVED_NV_BIT = 6;
  localparam int HIGH_DISABLE_BIT = 5;
  localparam int LOW_DISABLE_BIT = 2;
  localparam int VIOLATION_BIT = 4;
  localparam int CMD_OP_LSB = 24;
  localparam int RESULT_LOADED_BIT = 8;
  localparam int RESULT_LOAD_FAULT_BIT = 9;

  // Protection byte location and program-flash address map.
  localparam logic [22:0] PROT_BYTE_ADDR = 23'h7f_ff0c;
  localparam logic [22:0] PFLASH_TOP = 23'h7f_ffff;
  localparam logic [22:0] LOW_RANGE_BASE = 23'h7f_8000;
  localparam logic [22:0] HIGH_SIZE_2K = 23'h00_0800;
  localparam logic [22:0] LOW_SIZE_1K = 23'h00_0400;

  // Value held before the byte is loaded and after a double bit fault: fully protected.
  localparam logic [7:0] PROT_FULL_VALUE = 8'h7f;
  localparam logic [7:0] PROT_FAULT_MASK = 8'h80;

  // Allowed target scenarios, one row per current scenario, bit n set allows scenario n.
  localparam logic [7:0] TRANSITION_ROW [8] = '{
    8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff
  };

  // Scenario number for each {polarity, high disable, low disable} code.
  localparam logic [2:0] SCENARIO_OF_CODE [8] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7
  };

  typedef struct packed {
    logic polarity;
    logic reserved_nv;
    logic high_range_disable;
    logic [1:0] high_range_size;
    logic low_range_disable;
    logic [1:0] low_range_size;
  } pfpg_prot_s;

  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_SECTOR_ERASE = 2'h1,
    OP_BLOCK_ERASE = 2'h2,
    OP_ILLEGAL = 2'h3
  } pfpg_op_e;

  typedef struct packed {
    pfpg_op_e op;
    logic [22:0] addr;
  } pfpg_cmd_s;

  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_LAUNCHED = 2'h1,
    RES_PROTECTED = 2'h2,
    RES_BLOCKED = 2'h3
  } pfpg_result_e;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } pfpg_state_e;

endpackage

// file: core/pfpg_range_check.sv
`timescale 1ns/10ps
module pfpg_range_check (
  // Protection setting in force.
  input wire pfpg_pkg::pfpg_prot_s prot,
  // Target address of the command.
  input wire logic [22:0] addr,
  // Verdicts.
  output logic addr_protected,
  output logic block_protected
);

  logic [22:0] high_size;
  logic [22:0] low_size;
  logic [22:0] high_start;
  logic [22:0] low_end;
  logic in_high;
  logic in_low;
  logic hit;

  // Each size code doubles the range.
  assign high_size = pfpg_pkg::HIGH_SIZE_2K << prot.high_range_size;
  assign low_size = pfpg_pkg::LOW_SIZE_1K << prot.low_range_size;
  assign high_start = pfpg_pkg::PFLASH_TOP - high_size + 23'h00_0001;
  assign low_end = pfpg_pkg::LOW_RANGE_BASE + low_size;

  assign in_high = (addr >= high_start) && !prot.high_range_disable;
  assign in_low = (addr >= pfpg_pkg::LOW_RANGE_BASE) && (addr < low_end)
                  && !prot.low_range_disable;
  assign hit = in_high | in_low;

  // Set polarity: enabled ranges are protected; clear: they are the only open areas.
  assign addr_protected = prot.polarity ? hit : !hit;

  // With clear polarity some sector is always protected, since no open range spans a block.
  assign block_protected = prot.polarity ?
                           (!prot.high_range_disable | !prot.low_range_disable) :
                           1'b1;

endmodule // pfpg_range_check

// file: testbench/pfpg_top_properties.sv
`timescale 1ns/10ps
module pfpg_top_properties (
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Load link.
  input wire logic load_req,
  input wire logic load_valid,
  input wire logic [7:0] load_byte,
  input wire logic load_dbfault,
  // Outputs.
  input wire logic cmd_go,
  input wire pfpg_pkg::pfpg_cmd_s cmd,
  input wire pfpg_pkg::pfpg_prot_s prot_state,
  input wire logic violation
);
  localparam logic [7:0] ALLOWED [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
  logic wr, prot_wr, cmd_wr, clr_wr, ld;
  logic [2:0] cur, nxt;
  assign wr = psel && penable && pready && pwrite;
  assign prot_wr = wr && paddr == pfpg_pkg::PROT_OFFSET;
  assign cmd_wr = wr && paddr == pfpg_pkg::COMMAND_OFFSET;
  assign clr_wr = wr && paddr == pfpg_pkg::STATUS_OFFSET && pwdata[4];
  assign ld = load_req && load_valid;
  assign cur = {prot_state[7], prot_state[5], prot_state[2]};
  assign nxt = {pwdata[7], pwdata[5], pwdata[2]};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_LOAD_BYTE: assert property (
    ld && !load_dbfault |=> prot_state == $past(load_byte) && !load_req)
    else $error("protection byte not taken");
  AST_LOAD_FAULT: assert property (
    ld && load_dbfault |=> prot_state == 8'h7f) else $error("fault load not fully protected");
  AST_VIOL_CAUSE: assert property (
    $rose(violation) |-> $past(cmd_wr)) else $error("violation without command");
  AST_BLOCK_ERASE: assert property (
    cmd_go && cmd.op == pfpg_pkg::OP_BLOCK_ERASE |-> cur == 3'b111)
    else $error("block erase launched while protected");
  AST_FULL_PROT: assert property (
    cmd_go |-> cur != 3'b011) else $error("launch under full protection");
  AST_HIGH_SIZE: assert property (
    prot_wr && !prot_state[5] |=> prot_state[4:3] == $past(prot_state[4:3]))
    else $error("high size changed while enabled");
  AST_LOW_SIZE: assert property (
    prot_wr && !prot_state[2] |=> prot_state[1:0] == $past(prot_state[1:0]))
    else $error("low size changed while enabled");
  AST_BAD_MOVE: assert property (
    prot_wr && !ld && !ALLOWED[cur][nxt] |=> $stable(prot_state))
    else $error("disallowed scenario accepted");
  AST_PROT_HOLD: assert property (
    !prot_wr && !ld |=> $stable(prot_state)) else $error("protection changed unprompted");
  AST_VIOL_HOLD: assert property (
    violation && !clr_wr |=> violation) else $error("violation lost");
  AST_NO_GO: assert property (
    violation |=> !cmd_go) else $error("launch while violation set");
endmodule // pfpg_top_properties

bind pfpg_top pfpg_top_properties u_pfpg_top_properties (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .load_req, .load_valid, .load_byte, .load_dbfault,
  .cmd_go, .cmd, .prot_state, .violation);

// file: testbench/pfpg_top_tb.sv
`timescale 1ns/10ps
module pfpg_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic load_req, load_valid, load_dbfault, cmd_go, violation, serr;
  logic [7:0] paddr, load_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [22:0] load_addr;
  pfpg_pkg::pfpg_cmd_s cmd;
  pfpg_pkg::pfpg_prot_s prot_state;
  int err_count, n_tests;

  pfpg_top u_pfpg_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .load_req, .load_addr, .load_valid, .load_byte, .load_dbfault,
    .cmd_go, .cmd, .prot_state, .violation);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One idle edge ends each transfer so no request signal is driven twice in a step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; a slave that never answers is caught by the watchdog.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_load(input logic [7:0] b, input logic f, input logic [7:0] e);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(prot_state, 8'h7f);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(load_req, 1'b1);
    chk(load_addr, 23'h7f_ff0c);
    load_byte <= b;
    load_dbfault <= f;
    load_valid <= 1'b1;
    @(posedge pclk);
    load_valid <= 1'b0;
    @(posedge pclk);
    chk(prot_state, e);
    chk(load_req, 1'b0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, {22'h0, f, 9'h100});
  endtask

  task automatic t_wr(input logic [7:0] w, input logic [7:0] e);
    apb(1'b1, 8'h00, {24'h0, w});
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, {24'h0, e});
    chk(prot_state, e);
  endtask

  // A refused command only shows in the result code and the violation level.
  task automatic t_cmd(input logic [1:0] op, input logic [22:0] a, input logic [1:0] res);
    apb(1'b1, 8'h08, {6'h00, op, 1'b0, a});
    chk(cmd_go, res == 2'h1);
    if (res == 2'h1) begin
      chk(cmd, {op, a});
    end
    chk(violation, res[1]);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, {23'h0, 1'b1, 6'h0, res});
  endtask

  task automatic t_clear;
    apb(1'b1, 8'h04, 32'h0);
    chk(violation, 1'b1);
    apb(1'b1, 8'h04, 32'h10);
    chk(violation, 1'b0);
  endtask

  initial begin
    #20000;
    err_count++;
    stop_test;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {load_valid, load_byte, load_dbfault} = '0;
    @(posedge pclk);
    t_load(8'hff, 1'b0, 8'hff);
    t_cmd(2'h0, 23'h7f_8000, 2'h1);
    t_cmd(2'h0, 23'h7f_ff0c, 2'h1);
    t_cmd(2'h2, 23'h7f_8000, 2'h1);
    t_wr(8'hbb, 8'hfb);
    t_cmd(2'h0, 23'h7f_9fff, 2'h2);
    t_cmd(2'h0, 23'h7f_a000, 2'h3);
    t_clear;
    t_cmd(2'h0, 23'h7f_a000, 2'h1);
    t_cmd(2'h2, 23'h7f_c000, 2'h2);
    t_clear;
    t_wr(8'h00, 8'hfb);
    t_wr(8'h88, 8'hcb);
    t_cmd(2'h0, 23'h7f_f000, 2'h2);
    t_clear;
    t_cmd(2'h0, 23'h7f_efff, 2'h1);
    t_wr(8'h24, 8'h6f);
    t_cmd(2'h0, 23'h7f_a000, 2'h2);
    t_clear;
    t_wr(8'hff, 8'h6f);
    apb(1'b0, 8'h10, 32'h0);
    chk(serr, 1'b1);
    t_load(8'h00, 1'b1, 8'h7f);
    stop_test;
  end
endmodule // pfpg_top_tb
